// [sar_adc_ctrl_pkg.sv]
// Functional notes
// - single or free-running mode, chosen by free_run_select
// - writing one to enable bit enables converter
// - first conversion after enable adds dummy twelve cycles
// - start bit starts conversion, reads high, auto-clears in single mode
// - channel change applies only to the next conversion
// - ten-bit result split over low and high bytes
// - low byte read first; then result writes blocked
// - result finishing while blocked is discarded, registers kept
// - high byte read releases the result block
// - done flag set on every completion, even discarded
// - prescaler runs while enabled, held reset while off
// - conversion begins at next converter clock rising edge
// - sample-and-hold fires 1.5 converter cycles after begin
// - normal conversion writes result after 13 cycles
// - single mode: one idle cycle, start during it honoured
// - free running: next conversion starts right after result
// - dummy conversion samples at 13.5, result at 25
// - eight input channels selected by channel_select_reg
// - divider codes: 2,2,4,8,16,32,64,128
// - done flag cleared by vector acknowledge or write one
// - writing zero to start bit has no effect
// - clearing enable aborts conversion, converter off
`default_nettype none

package sar_adc_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices and byte addresses
  localparam logic [7:0] IDX_RESULT_LOW  = 8'h04;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h05;
  localparam logic [7:0] IDX_CTRL_STATUS = 8'h06;
  localparam logic [7:0] IDX_CHAN_SELECT = 8'h07;

  function automatic logic [7:0] reg_addr(input logic [7:0] idx);
    reg_addr = {idx[5:0], 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // conv_ctrl_status field positions
  localparam int POS_ENABLE   = 7;
  localparam int POS_START    = 6;
  localparam int POS_FREE_RUN = 5;
  localparam int POS_DONE     = 4;
  localparam int POS_IRQ_EN   = 3;
  localparam int POS_DIV_LSB  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // timing in converter clock cycles
  localparam logic [4:0] CYC_SAMPLE_NORMAL = 5'h02;
  localparam logic [4:0] CYC_RESULT_NORMAL = 5'h0d;
  localparam logic [4:0] CYC_DUMMY_EXTRA   = 5'h0c;
  localparam logic [4:0] CYC_FIRST         = 5'h01;
  localparam int         CONV_CLK_MIN_KHZ  = 50;
  localparam int         CONV_CLK_MAX_KHZ  = 200;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_HOLD = 3'b100
  } conv_state_t;

  typedef struct packed {
    conv_state_t st;
    logic [6:0]  pre_cnt;
    logic [4:0]  cyc;
    logic        dummy_pend;
    logic        dummy_act;
    logic        en;
    logic        start;
    logic        free_run;
    logic        done;
    logic        irq_en;
    logic [2:0]  div_sel;
    logic [2:0]  chan;
    logic [2:0]  mux_sel;
    logic [9:0]  result;
    logic        lock;
    logic [9:0]  core_meta;
    logic [9:0]  core_sync;
    logic        sample_hold;
    logic        conv_active;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ctrl_state_t;

  localparam ctrl_state_t RESET_STATE = '{
    st: ST_IDLE, pre_cnt: 7'h00, cyc: 5'h00, dummy_pend: 1'b0, dummy_act: 1'b0,
    en: 1'b0, start: 1'b0, free_run: 1'b0, done: 1'b0, irq_en: 1'b0,
    div_sel: 3'h0, chan: 3'h0, mux_sel: 3'h0, result: 10'h000, lock: 1'b0,
    core_meta: 10'h000, core_sync: 10'h000, sample_hold: 1'b0,
    conv_active: 1'b0, irq: 1'b0, pready: 1'b0, pslverr: 1'b0,
    prdata: 32'h0000_0000
  };

endpackage

`default_nettype wire

// [sar_adc_ctrl.sv]
// The implementer's own choices: the register offsets and the APB slave port.
`default_nettype none

module sar_adc_ctrl
  import sar_adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // cpu interrupt system
  input  wire logic        global_int_en,
  input  wire logic        vector_ack,
  output logic             conv_irq,
  // analog side
  input  wire logic [9:0]  core_result,
  output logic [2:0]       mux_sel,
  output logic             sample_hold,
  output logic             conv_active,
  output logic             conv_on
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // divide-by minus one, so the prescaler wraps at this count
  function automatic logic [6:0] div_limit(input logic [2:0] sel);
    unique case (sel)
      3'h0, 3'h1: div_limit = 7'h01;
      3'h2:       div_limit = 7'h03;
      3'h3:       div_limit = 7'h07;
      3'h4:       div_limit = 7'h0f;
      3'h5:       div_limit = 7'h1f;
      3'h6:       div_limit = 7'h3f;
      3'h7:       div_limit = 7'h7f;
    endcase
  endfunction

  // one aligned word per register, so the whole byte address must match
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] idx);
    is_reg = (a == reg_addr(idx));
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = is_reg(a, IDX_RESULT_LOW)  ||
               is_reg(a, IDX_RESULT_HIGH) ||
               is_reg(a, IDX_CTRL_STATUS) ||
               is_reg(a, IDX_CHAN_SELECT);
  endfunction

  // status byte packed from the field positions, so the map lives in one place
  function automatic logic [7:0] csr_byte(input ctrl_state_t s);
    logic [7:0] b;
    b                   = 8'h00;
    b[POS_ENABLE]       = s.en;
    b[POS_START]        = s.start;
    b[POS_FREE_RUN]     = s.free_run;
    b[POS_DONE]         = s.done;
    b[POS_IRQ_EN]       = s.irq_en;
    b[POS_DIV_LSB +: 3] = s.div_sel;
    csr_byte            = b;
  endfunction

  // reserved and unmapped bits read as zero
  function automatic logic [31:0] read_word(input ctrl_state_t s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (is_reg(a, IDX_RESULT_LOW)) begin
      w[7:0] = s.result[7:0];
    end else if (is_reg(a, IDX_RESULT_HIGH)) begin
      w[1:0] = s.result[9:8];
    end else if (is_reg(a, IDX_CTRL_STATUS)) begin
      w[7:0] = csr_byte(s);
    end else if (is_reg(a, IDX_CHAN_SELECT)) begin
      w[2:0] = s.chan;
    end
    read_word = w;
  endfunction

  // the initialising pass moves every milestone by the same count
  function automatic logic [4:0] conv_mark(input logic dummy, input logic [4:0] normal);
    if (dummy) begin
      conv_mark = normal + CYC_DUMMY_EXTRA;
    end else begin
      conv_mark = normal;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  logic [6:0] lim;
  logic       rise_tick;
  logic       fall_tick;
  logic       setup_ph;
  logic       wr_acc;
  logic       rd_acc;
  logic       start_wr;
  logic       done_clr;
  logic       done_set;
  logic [4:0] samp_cyc;
  logic [4:0] end_cyc;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;

    // prescaler: counts only while enabled, otherwise held at zero
    lim       = div_limit(s_q.div_sel);
    rise_tick = s_q.en && (s_q.pre_cnt >= lim);
    fall_tick = s_q.en && (s_q.pre_cnt == (lim >> 1));
    if (!s_q.en) begin
      s_d.pre_cnt = 7'h00;
    end else if (rise_tick) begin
      s_d.pre_cnt = 7'h00;
    end else begin
      s_d.pre_cnt = s_q.pre_cnt + 7'h01;
    end

    // analog result crosses in through two flops
    s_d.core_meta = core_result;
    s_d.core_sync = s_q.core_meta;

    ////////////////////////////////////////////////////////////////////////
    // apb: ready in the first access cycle, no wait state; read data comes from a flop
    setup_ph  = psel && !penable && !s_q.pready;
    wr_acc    = psel && penable && s_q.pready && pwrite;
    rd_acc    = psel && penable && s_q.pready && !pwrite;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    if (setup_ph) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = !addr_hit(paddr);
      s_d.prdata  = 32'h0000_0000;
      if (!pwrite) begin
        s_d.prdata = read_word(s_q, paddr);
      end
    end

    // result protection, taken on the completing read edge
    if (rd_acc && is_reg(paddr, IDX_RESULT_LOW)) begin
      s_d.lock = 1'b1;
    end
    if (rd_acc && is_reg(paddr, IDX_RESULT_HIGH)) begin
      s_d.lock = 1'b0;
    end

    // register writes
    start_wr = 1'b0;
    done_clr = 1'b0;
    if (wr_acc && is_reg(paddr, IDX_CTRL_STATUS)) begin
      s_d.en       = pwdata[POS_ENABLE];
      s_d.free_run = pwdata[POS_FREE_RUN];
      s_d.irq_en   = pwdata[POS_IRQ_EN];
      s_d.div_sel  = pwdata[POS_DIV_LSB +: 3];
      done_clr     = pwdata[POS_DONE];
      if (pwdata[POS_ENABLE] && !s_q.en) begin
        s_d.dummy_pend = 1'b1;
      end
      // a zero written to start leaves any conversion alone
      if (pwdata[POS_START] && pwdata[POS_ENABLE]) begin
        start_wr  = 1'b1;
        s_d.start = 1'b1;
      end
    end
    if (wr_acc && is_reg(paddr, IDX_CHAN_SELECT)) begin
      s_d.chan = pwdata[2:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion sequencer, stepped by converter clock pulses
    done_set        = 1'b0;
    s_d.sample_hold = 1'b0;
    samp_cyc = conv_mark(s_q.dummy_act, CYC_SAMPLE_NORMAL);
    end_cyc  = conv_mark(s_q.dummy_act, CYC_RESULT_NORMAL);
    if (!s_q.en) begin
      // disabling kills the conversion in flight, result is not written
      s_d.st        = ST_IDLE;
      s_d.cyc       = 5'h00;
      s_d.dummy_act = 1'b0;
      s_d.start     = start_wr;
    end else begin
      unique case (s_q.st)
        ST_IDLE: begin
          // the begin always lines up with a converter clock edge
          if (rise_tick && s_q.start) begin
            s_d.st         = ST_CONV;
            s_d.cyc        = CYC_FIRST;
            s_d.mux_sel    = s_q.chan;
            s_d.dummy_act  = s_q.dummy_pend;
            s_d.dummy_pend = 1'b0;
          end
        end
        ST_HOLD: begin
          // extra cycle after a single result; a start seen here runs at once
          if (rise_tick) begin
            if (s_q.start) begin
              s_d.st         = ST_CONV;
              s_d.cyc        = CYC_FIRST;
              s_d.mux_sel    = s_q.chan;
              s_d.dummy_act  = s_q.dummy_pend;
              s_d.dummy_pend = 1'b0;
            end else begin
              s_d.st = ST_IDLE;
            end
          end
        end
        ST_CONV: begin
          // half a converter cycle into the sample cycle
          // an abort taken on this edge must not fire the hold switch
          if (fall_tick && (s_q.cyc == samp_cyc) && s_d.en) begin
            s_d.sample_hold = 1'b1;
          end
          if (rise_tick) begin
            if (s_q.cyc == end_cyc) begin
              done_set      = 1'b1;
              s_d.dummy_act = 1'b0;
              if (!s_q.lock) begin
                s_d.result = s_q.core_sync;
              end
              if (s_q.free_run) begin
                s_d.cyc     = CYC_FIRST;
                s_d.mux_sel = s_q.chan;
              end else begin
                s_d.st  = ST_HOLD;
                s_d.cyc = 5'h00;
                if (!start_wr) begin
                  s_d.start = 1'b0;
                end
              end
            end else begin
              s_d.cyc = s_q.cyc + 5'h01;
            end
          end
        end
        default: begin
          s_d.st = ST_IDLE;
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // done flag: a completion in the clearing cycle still sets it
    if (done_set) begin
      s_d.done = 1'b1;
    end else if (done_clr || vector_ack) begin
      s_d.done = 1'b0;
    end

    s_d.irq         = s_d.done && s_d.irq_en && global_int_en;
    s_d.conv_active = (s_d.st == ST_CONV);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops

  assign prdata      = s_q.prdata;
  assign pready      = s_q.pready;
  assign pslverr     = s_q.pslverr;
  assign conv_irq    = s_q.irq;
  assign mux_sel     = s_q.mux_sel;
  assign sample_hold = s_q.sample_hold;
  assign conv_active = s_q.conv_active;
  assign conv_on     = s_q.en;

endmodule

`default_nettype wire

// [sar_adc_ctrl_monitor.sv]
`default_nettype none
module sar_adc_ctrl_monitor (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // converter
  input wire logic        global_int_en,
  input wire logic        conv_irq,
  input wire logic        sample_hold,
  input wire logic        conv_active,
  input wire logic        conv_on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  pready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer one cycle after setup");
  pready_single_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  unmapped_err_a: assert property (psel && !penable && paddr == 8'h00 |=> pslverr)
    else $error("unmapped access not refused");
  err_data_zero_a: assert property (pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read carries data");
  irq_gated_a: assert property (!global_int_en |=> !conv_irq)
    else $error("request while globally masked");
  hold_pulse_a: assert property (sample_hold |=> !sample_hold)
    else $error("sample pulse wider than one cycle");
  hold_in_conv_a: assert property (sample_hold |-> conv_active && conv_on)
    else $error("sample outside a conversion");
  // at the fastest divider 1.5 ticks still leaves the first cycles free
  hold_delay_a: assert property ($rose(conv_active) |-> !sample_hold[*2])
    else $error("sample too soon after begin");
  abort_disable_a: assert property ($fell(conv_on) |=> !conv_active)
    else $error("conversion not aborted");
endmodule
bind sar_adc_ctrl sar_adc_ctrl_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .global_int_en(global_int_en), .conv_irq(conv_irq), .sample_hold(sample_hold),
  .conv_active(conv_active), .conv_on(conv_on));
`default_nettype wire

// [sar_adc_core_model.sv]
`default_nettype none
module sar_adc_core_model (
  // clock and reset
  input wire logic  pclk,
  input wire logic  presetn,
  // control
  input wire logic  sample_hold,
  // result
  output logic [9:0] core_result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] seq_q;
  // high bits repeat low bits so a torn read of the two bytes shows up
  assign core_result = {seq_q[1:0], seq_q};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= 8'h00;
    end else if (sample_hold) begin
      seq_q <= seq_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [sar_adc_ctrl_tb.sv]
`default_nettype none
module sar_adc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_LOW = 8'h10, A_HIGH = 8'h14, A_CTRL = 8'h18, A_CHAN = 8'h1c;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        global_int_en = 0, vector_ack = 0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, conv_irq, sample_hold, conv_active, conv_on;
  logic [9:0]  core_result;
  logic [2:0]  mux_sel;
  int          errors = 0, n_tests = 0, n;
  always #12.5 pclk = ~pclk;
  sar_adc_ctrl u_sar_adc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_int_en(global_int_en), .vector_ack(vector_ack),
    .conv_irq(conv_irq), .core_result(core_result), .mux_sel(mux_sel),
    .sample_hold(sample_hold), .conv_active(conv_active), .conv_on(conv_on));
  sar_adc_core_model u_sar_adc_core_model (.pclk(pclk), .presetn(presetn),
    .sample_hold(sample_hold), .core_result(core_result));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("errors=%0d tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic hang;
    errors++;
    $display("MISMATCH t=%0t wait ran out", $time);
    summarize();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one idle cycle between transfers keeps each strobe single-driven per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wait_sh(output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (sample_hold !== 1'b1 && c < 5000);
    if (c >= 5000) hang();
  endtask
  task automatic run_len(output int c);
    int g;
    g = 0;
    c = 0;
    while (conv_active !== 1'b1 && g < 500) begin @(posedge pclk); g++; end
    while (conv_active === 1'b1 && c < 5000) begin @(posedge pclk); c++; end
    if (g >= 500 || c >= 5000) hang();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int a = 16; a < 32; a += 4) begin
      apb(1'b0, a[7:0], 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h00, 32'h0);
    chk(err, 1'b1);
  endtask
  task automatic t_dummy;
    global_int_en <= 1'b1;
    apb(1'b1, A_CHAN, 32'h3);
    apb(1'b1, A_CTRL, 32'hc8);
    run_len(n);
    chk(n >= 48 && n <= 52, 1'b1);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd[6], 1'b0);
    chk(rd[4], 1'b1);
    chk(conv_irq, 1'b1);
    chk(mux_sel, 3'h3);
    apb(1'b0, A_LOW, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, A_HIGH, 32'h0);
    chk(rd, 32'h1);
  endtask
  task automatic t_chan;
    apb(1'b1, A_CTRL, 32'hc8);
    apb(1'b1, A_CHAN, 32'h5);
    chk(mux_sel, 3'h3);
    run_len(n);
    apb(1'b0, A_LOW, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, A_CTRL, 32'hc8);
    run_len(n);
    chk(n >= 26 && n <= 28, 1'b1);
    chk(mux_sel, 3'h5);
  endtask
  task automatic t_lock;
    // the low read in t_chan left the block set, so that result was dropped
    apb(1'b1, A_CTRL, 32'h98);
    apb(1'b0, A_LOW, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, A_CTRL, 32'hc8);
    run_len(n);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd[4], 1'b1);
    apb(1'b0, A_HIGH, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, A_CTRL, 32'hc8);
    run_len(n);
    apb(1'b0, A_LOW, 32'h0);
    chk(rd, 32'h5);
    apb(1'b0, A_HIGH, 32'h0);
    chk(rd, 32'h1);
    global_int_en <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(conv_irq, 1'b0);
    vector_ack <= 1'b1;
    @(posedge pclk);
    vector_ack <= 1'b0;
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd[4], 1'b0);
  endtask
  // every code sits above the accurate band at this pclk; the ideal model keeps runs short
  // free-running sample spacing reveals the divided clock period for every code
  task automatic t_div;
    for (int code = 0; code < 8; code++) begin
      apb(1'b1, A_CTRL, 32'h0);
      apb(1'b1, A_CTRL, 32'he0 | code);
      wait_sh(n);
      wait_sh(n);
      wait_sh(n);
      chk(n, 13 * ((code < 2) ? 2 : (1 << code)));
      apb(1'b0, A_CTRL, 32'h0);
      chk(rd[6], 1'b1);
      apb(1'b1, A_CTRL, 32'h0);
      repeat (2) @(posedge pclk);
      chk({conv_on, conv_active}, 2'b00);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_dummy();
    t_chan();
    t_lock();
    t_div();
    summarize();
  end
endmodule
`default_nettype wire
